// ==== dv/osl_loader_bench.sv ====
// Purpose: Self-checking bench of the setting loader.
// Assumes: Array model answers promptly or every other cycle.
// Notes:   The loop check count is cut to 4 cycles.
`include "osl_params.svh"
`default_nettype none
module osl_loader_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 0, aresetn = 0, slow = 0, cut = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, otp_rdata;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, r;
	logic [3:0] s_axi_wstrb = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, otp_req, otp_ack, loop_out_pin, loop_in_pin;
	logic [1:0] s_axi_bresp, s_axi_rresp, resolution_select, bresp, rresp;
	logic [12:0] otp_addr;
	logic reg_source_select, colour_mode_bit, gate_scan_direction;
	logic source_shift_direction, three_colour_mode, deep_sleep, irq;
	int error_cnt = 0, n_tests = 0;
	localparam logic [7:0] BND [6] = '{8'hF1, 8'hFB, 8'h00, 8'h0A, 8'h1E, 8'h7F};
	assign loop_in_pin = loop_out_pin & ~cut;
	initial forever #2.5 aclk = ~aclk;
	osl_loader #(.LOOP_CYC(4)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .otp_req,
		.otp_addr, .otp_ack, .otp_rdata, .loop_out_pin, .loop_in_pin,
		.resolution_select, .reg_source_select, .colour_mode_bit,
		.gate_scan_direction, .source_shift_direction, .three_colour_mode,
		.deep_sleep, .irq);
	osl_otp_model i_otp (.aclk, .slow, .otp_req, .otp_addr, .otp_ack,
		.otp_rdata);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic rst;
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask
	// The bench acts as the host of a single chip of a cascade.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		if (s_axi_bvalid !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t write response timed out", $time);
		end
		bresp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		if (s_axi_rvalid !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t read response timed out", $time);
		end
		r = s_axi_rdata;
		rresp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic poll(input logic [2:0] m);
		for (int n = 0; n < 200; n++) begin
			rd(`OSL_A_INT_STAT);
			if ((r[2:0] & m) != 3'h0) return;
		end
		error_cnt++;
		$display("[FAIL] %0t event poll timed out", $time);
	endtask
	task automatic load(input logic [7:0] t);
		wr(`OSL_A_TEMP, {24'h0, t});
		wr(`OSL_A_CTRL, 32'h1);
		poll(3'h3);
		wr(`OSL_A_INT_STAT, 32'h7);
	endtask
	task automatic bank(input logic [12:0] b, input logic [7:0] k, p);
		i_otp.mem[b] = `OSL_CHECK_CODE;
		i_otp.mem[b + 13'h1] = k;
		i_otp.mem[b + 13'h2] = p;
		for (int i = 0; i < 6; i++)
			i_otp.mem[b + 13'h1A + 13'(i)] = BND[i];
		for (int s = 0; s < 17; s++)
			for (int j = 0; j < 9; j++)
				i_otp.mem[b + 13'h2A + 13'(s * 233 + j)] = 8'(s * 16 + j);
	endtask
	function automatic logic [31:0] hdr(input int s);
		return {8'(s * 16 + 3), 8'(s * 16 + 2), 8'(s * 16 + 1), 8'(s * 16)};
	endfunction
	function automatic logic [31:0] pnl();
		return {26'h0, resolution_select, reg_source_select, colour_mode_bit,
			gate_scan_direction, source_shift_direction};
	endfunction
	task automatic t_range;
		logic [7:0] tv [7] = '{8'hEC, 8'hF1, 8'hF6, 8'h00, 8'h14, 8'h28, 8'h70};
		int sl [7] = '{0, 0, 1, 2, 4, 5, 5};
		rst;
		chk(pnl(), 32'h03);
		chk({deep_sleep, irq, three_colour_mode}, 3'b001);
		rd(8'h30);
		chk({rresp, r[29:0]}, {`OSL_RESP_SLVERR, 30'h0});
		wr(8'h40, 32'h1);
		chk(bresp, `OSL_RESP_SLVERR);
		bank(13'h0000, `OSL_CHECK_CODE, 8'hA4);
		for (int i = 0; i < 7; i++) begin
			slow <= 1'(i);
			load(tv[i]);
			rd(`OSL_A_RANGE);
			chk(r[4:0], 32'(sl[i]));
			rd(`OSL_A_HDR0);
			chk(r, hdr(sl[i]));
		end
		chk(pnl(), 32'h29);
		rd(`OSL_A_STATUS);
		chk(r[4:2], 3'b101);
		wr(`OSL_A_DEF_IDX, 32'h2);
		rd(`OSL_A_DEF_DATA);
		chk(r[7:0], 8'hA4);
		rd(`OSL_A_SHAPE);
		chk(r[7:0], 8'h84);
		for (int i = 0; i < 16; i++)
			i_otp.mem[13'h1A + 13'(i)] = 8'(i);
		load(8'h0F);
		rd(`OSL_A_RANGE);
		chk(r[4:0], 5'h0F);
		load(8'h20);
		rd(`OSL_A_RANGE);
		chk(r[4:0], `OSL_FINAL_SLOT);
		rd(`OSL_A_HDR0);
		chk(r, hdr(16));
		rd(`OSL_A_HDR1);
		chk(r, 32'h0706_0504);
		$display("range selection test done");
	endtask
	task automatic t_bank1;
		rst;
		i_otp.mem[0] = 8'hFF;
		bank(13'h1000, 8'h00, 8'hB4);
		load(8'hF6);
		rd(`OSL_A_RANGE);
		chk(r[4:0], 5'h01);
		rd(`OSL_A_HDR0);
		chk(r, hdr(1));
		rd(`OSL_A_STATUS);
		chk(r[4:3], 2'b01);
		wr(`OSL_A_DEF_IDX, 32'h2);
		rd(`OSL_A_DEF_DATA);
		chk(r[7:0], `OSL_PSR_DEFAULT);
		chk(pnl(), 32'h03);
		bank(13'h1000, `OSL_CHECK_CODE, 8'h10);
		load(8'hF6);
		rd(`OSL_A_SHAPE);
		chk(r[7:0], 8'h65);
		chk(three_colour_mode, 1'b0);
		i_otp.mem[13'h1000] = 8'hFF;
		wr(`OSL_A_INT_MASK, 32'h2);
		wr(`OSL_A_CTRL, 32'h1);
		poll(3'h2);
		chk({r[1:0], irq}, 3'b101);
		wr(`OSL_A_INT_STAT, 32'h2);
		chk(irq, 1'b0);
		$display("bank choice test done");
	endtask
	task automatic t_loop_sleep;
		wr(`OSL_A_INT_MASK, 32'h4);
		for (int i = 0; i < 2; i++) begin
			cut <= 1'(i);
			wr(`OSL_A_CTRL, 32'h2);
			poll(3'h4);
			chk(irq, 1'b1);
			rd(`OSL_A_STATUS);
			chk({r[7], loop_out_pin}, {1'(1 - i), 1'b0});
			wr(`OSL_A_INT_STAT, 32'h4);
		end
		wr(`OSL_A_CMD, 32'h6);
		chk(deep_sleep, 1'b0);
		wr(`OSL_A_CMD, 32'h7);
		wr(`OSL_A_CMD, 32'h0);
		rd(`OSL_A_CMD);
		chk({r[0], deep_sleep}, 2'b11);
		wr(`OSL_A_CTRL, 32'h1);
		rd(`OSL_A_STATUS);
		chk({r[5], r[1]}, 2'b10);
		rst;
		chk(deep_sleep, 1'b0);
		$display("loop and sleep test done");
	endtask
	initial begin
		#200000;
		error_cnt++;
		$display("[FAIL] %0t watchdog expired", $time);
		complete_run;
	end
	initial begin
		t_range;
		t_bank1;
		t_loop_sleep;
		complete_run;
	end
endmodule
`default_nettype wire

// ==== dv/osl_otp_model.sv ====
// Purpose: Behavioural nonvolatile array behind the setting loader.
// Assumes: Erased cells read FF; the bench fills the contents.
// Notes:   With slow set, only every other request cycle is taken.
`default_nettype none
module osl_otp_model (
	input  wire logic        aclk,
	input  wire logic        slow,
	input  wire logic        otp_req,
	input  wire logic [12:0] otp_addr,
	output logic             otp_ack,
	output logic [7:0]       otp_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:8191];
	logic [7:0] last = 8'h00;
	logic       ph   = 1'b0;
	initial begin
		for (int i = 0; i < 8192; i++)
			mem[i] = 8'hFF;
	end
	always @(posedge aclk) begin
		ph <= ~ph;
		if (otp_ack)
			last <= otp_rdata;
	end
	assign otp_ack = otp_req & (~slow | ph);
	// Data outside an acknowledged cycle is inverted so nothing stale passes.
	assign otp_rdata = otp_ack ? mem[otp_addr] : ~last;
endmodule
`default_nettype wire

// ==== src/osl_bound_cmp.sv ====
// Purpose: Compares a measured temperature with one stored boundary.
// Assumes: Both operands are two's-complement whole degrees.
// Notes:   The terminator code ends the chain wherever it stands.
`include "osl_params.svh"
`default_nettype none
module osl_bound_cmp #(
	parameter int            W    = 8,
	parameter logic [W-1:0]  TERM = `OSL_TERM_CODE
) (
	input  wire logic [W-1:0] temp,
	input  wire logic [W-1:0] bound,
	output logic              hit,
	output logic              term
);
	assign term = (bound == TERM);
	assign hit  = ($signed(temp) <= $signed(bound)) || term;
endmodule
`default_nettype wire

// ==== src/osl_byte_mem.sv ====
// Purpose: Small byte store with registered read data.
// Assumes: One write port and one read port on one clock.
// Notes:   Contents are undefined until written; readers gate on a flag.
`default_nettype none
module osl_byte_mem #(
	parameter int W     = 8,
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	input  wire logic          aclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);
	logic [W-1:0] mem [0:DEPTH-1];

	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// ==== src/osl_loader.sv ====
// Purpose: Nonvolatile setting loader with an AXI4-Lite register slave.
// Assumes: The array answers a held request with ack and data in one cycle.
// Notes:   Register slave, array walker and loop check share one clock.
// Summary of operation
// - Try bank check byte A5 at first bank, then second, else stop.
// - Walk boundaries upward; first boundary at or above temperature wins.
// - Temperature above the last boundary selects the final seventeenth slot.
// - Boundaries and temperature compare as signed whole degrees.
// - Boundary byte 7F ends the chain and selects its own position.
// - Override bytes after the key, up to 13h, load only with key A5.
// - Panel byte bits 7..2 give resolution, source, colour, scan; default 0F.
// - Seventeen records per bank; chosen record header is fetched as one set.
// - Three-colour mode: four tables of eight stages each.
// - Two-colour mode: five tables of six stages, rest reserved.
// - All tables of a record share one stage count.
// - Command 07h enters deep sleep; only reset assertion leaves it.
// - Loop check drives the out pin and passes only if it returns.
`include "osl_params.svh"
`default_nettype none
module osl_loader #(
	parameter int LOOP_CYC = `OSL_LOOP_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             otp_req,
	output logic [12:0]      otp_addr,
	input  wire logic        otp_ack,
	input  wire logic [7:0]  otp_rdata,
	output logic             loop_out_pin,
	input  wire logic        loop_in_pin,
	output logic [1:0]       resolution_select,
	output logic             reg_source_select,
	output logic             colour_mode_bit,
	output logic             gate_scan_direction,
	output logic             source_shift_direction,
	output logic             three_colour_mode,
	output logic             deep_sleep,
	output logic             irq
);
	osl_pkg::osl_state_t state;
	logic [12:0] bank_base;
	logic [4:0]  idx;
	logic [4:0]  sel_range;
	logic        key_ok;
	logic        bank_sel;
	logic        load_valid;
	logic [7:0]  panel_byte;
	logic [7:0]  hdr [0:8];
	logic [7:0]  temp;
	logic [4:0]  def_idx;
	logic [7:0]  def_mem_q;
	logic        ev_done;
	logic        ev_stop;
	logic        ev_loop;
	logic [2:0]  int_stat;
	logic [2:0]  int_mask;
	logic        loop_busy;
	logic        loop_ok;
	logic [15:0] loop_cnt;
	logic        cmp_hit;
	logic        cmp_term;
	logic        mem_we;
	logic        taken;
	logic [4:0]  next_range;
	logic [12:0] rec_addr;
	logic        aw_hold;
	logic        w_hold;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        wr_fire;
	logic        wr_ctrl_start;
	logic        wr_ctrl_loop;
	logic [31:0] rd_mux;
	logic        rd_ok;
	logic [7:0]  def_byte;

	function automatic logic [7:0] osl_builtin(input logic [4:0] i);
		case (i)
			5'h02:   osl_builtin = `OSL_PSR_DEFAULT;
			5'h04:   osl_builtin = 8'h17;
			5'h05:   osl_builtin = 8'h17;
			5'h06:   osl_builtin = 8'h17;
			5'h08:   osl_builtin = 8'hD7;
			5'h09:   osl_builtin = 8'h22;
			5'h12:   osl_builtin = 8'h03;
			default: osl_builtin = 8'h00;
		endcase
	endfunction

	osl_bound_cmp #(.W(8), .TERM(`OSL_TERM_CODE)) u_cmp (
		.temp  (temp),
		.bound (otp_rdata),
		.hit   (cmp_hit),
		.term  (cmp_term)
	);

	osl_byte_mem #(.W(8), .DEPTH(32), .AW(5)) u_defaults (
		.aclk  (aclk),
		.we    (mem_we),
		.waddr (idx),
		.wdata (otp_rdata),
		.raddr (def_idx),
		.rdata (def_mem_q)
	);

	assign otp_req = (state != osl_pkg::OSL_ST_IDLE);
	assign taken   = otp_req && otp_ack;
	assign mem_we  = taken && (state == osl_pkg::OSL_ST_DEF);
	// Past the last boundary the chain falls through to the final slot.
	assign next_range = (idx == `OSL_BND_LAST && !cmp_hit) ?
		`OSL_FINAL_SLOT : idx;
	assign rec_addr = bank_base + `OSL_REC_OFS +
		13'({8'h00, next_range} * `OSL_REC_LEN);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state      <= osl_pkg::OSL_ST_IDLE;
			otp_addr   <= 13'h0000;
			bank_base  <= 13'h0000;
			bank_sel   <= 1'b0;
			idx        <= 5'h00;
			sel_range  <= 5'h00;
			key_ok     <= 1'b0;
			load_valid <= 1'b0;
			ev_done    <= 1'b0;
			ev_stop    <= 1'b0;
		end else begin
			ev_done <= 1'b0;
			ev_stop <= 1'b0;
			case (state)
				osl_pkg::OSL_ST_IDLE: begin
					if (wr_ctrl_start && !deep_sleep) begin
						state      <= osl_pkg::OSL_ST_CHK0;
						otp_addr   <= `OSL_BANK0;
						bank_base  <= `OSL_BANK0;
						bank_sel   <= 1'b0;
						load_valid <= 1'b0;
					end
				end
				osl_pkg::OSL_ST_CHK0: begin
					if (otp_ack && otp_rdata == `OSL_CHECK_CODE) begin
						state    <= osl_pkg::OSL_ST_KEY;
						otp_addr <= `OSL_BANK0 + `OSL_KEY_OFS;
					end else if (otp_ack) begin
						state     <= osl_pkg::OSL_ST_CHK1;
						otp_addr  <= `OSL_BANK1;
						bank_base <= `OSL_BANK1;
						bank_sel  <= 1'b1;
					end
				end
				osl_pkg::OSL_ST_CHK1: begin
					if (otp_ack && otp_rdata == `OSL_CHECK_CODE) begin
						state    <= osl_pkg::OSL_ST_KEY;
						otp_addr <= `OSL_BANK1 + `OSL_KEY_OFS;
					end else if (otp_ack) begin
						state   <= osl_pkg::OSL_ST_IDLE;
						ev_stop <= 1'b1;
					end
				end
				osl_pkg::OSL_ST_KEY: begin
					if (otp_ack) begin
						key_ok <= (otp_rdata == `OSL_CHECK_CODE);
						if (otp_rdata == `OSL_CHECK_CODE) begin
							state    <= osl_pkg::OSL_ST_DEF;
							idx      <= `OSL_DEF_FIRST;
							otp_addr <= bank_base + 13'(`OSL_DEF_FIRST);
						end else begin
							state    <= osl_pkg::OSL_ST_BND;
							idx      <= 5'h00;
							otp_addr <= bank_base + `OSL_BND_OFS;
						end
					end
				end
				osl_pkg::OSL_ST_DEF: begin
					if (otp_ack && idx == `OSL_DEF_LAST) begin
						state    <= osl_pkg::OSL_ST_BND;
						idx      <= 5'h00;
						otp_addr <= bank_base + `OSL_BND_OFS;
					end else if (otp_ack) begin
						idx      <= idx + 5'h01;
						otp_addr <= otp_addr + 13'h0001;
					end
				end
				osl_pkg::OSL_ST_BND: begin
					// Ascending walk; a hit or a terminator ends it.
					if (otp_ack && (cmp_hit || idx == `OSL_BND_LAST)) begin
						state     <= osl_pkg::OSL_ST_HDR;
						sel_range <= next_range;
						otp_addr  <= rec_addr;
						idx       <= 5'h00;
					end else if (otp_ack) begin
						idx      <= idx + 5'h01;
						otp_addr <= otp_addr + 13'h0001;
					end
				end
				osl_pkg::OSL_ST_HDR: begin
					if (otp_ack && idx == `OSL_HDR_LAST) begin
						state      <= osl_pkg::OSL_ST_IDLE;
						load_valid <= 1'b1;
						ev_done    <= 1'b1;
					end else if (otp_ack) begin
						idx      <= idx + 5'h01;
						otp_addr <= otp_addr + 13'h0001;
					end
				end
				default: begin
					state <= osl_pkg::OSL_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 9; i++) begin
				hdr[i] <= 8'h00;
			end
		end else if (taken && state == osl_pkg::OSL_ST_HDR) begin
			hdr[idx[3:0]] <= otp_rdata;
		end
	end

	// Panel byte follows the override only while the key was present.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			panel_byte <= `OSL_PSR_DEFAULT;
		end else if (state == osl_pkg::OSL_ST_KEY && otp_ack &&
				otp_rdata != `OSL_CHECK_CODE) begin
			panel_byte <= `OSL_PSR_DEFAULT;
		end else if (mem_we && idx == `OSL_DEF_FIRST) begin
			panel_byte <= {otp_rdata[7:2], 2'b00};
		end
	end

	assign resolution_select      = panel_byte[7:6];
	assign reg_source_select      = panel_byte[5];
	assign colour_mode_bit        = panel_byte[4];
	assign gate_scan_direction    = panel_byte[3];
	assign source_shift_direction = panel_byte[2];
	assign three_colour_mode      = !panel_byte[4];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			deep_sleep <= 1'b0;
		end else if (wr_fire && aw_addr_q == `OSL_A_CMD && w_strb_q[0] &&
				w_data_q[7:0] == `OSL_SLEEP_CODE) begin
			deep_sleep <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			loop_busy    <= 1'b0;
			loop_ok      <= 1'b0;
			loop_out_pin <= 1'b0;
			loop_cnt     <= 16'h0000;
			ev_loop      <= 1'b0;
		end else begin
			ev_loop <= 1'b0;
			if (!loop_busy && wr_ctrl_loop && !deep_sleep) begin
				loop_busy    <= 1'b1;
				loop_out_pin <= 1'b1;
				loop_cnt     <= 16'(LOOP_CYC - 1);
			end else if (loop_busy && loop_cnt == 16'h0000) begin
				loop_busy    <= 1'b0;
				loop_out_pin <= 1'b0;
				loop_ok      <= loop_in_pin;
				ev_loop      <= 1'b1;
			end else if (loop_busy) begin
				loop_cnt <= loop_cnt - 16'h0001;
			end
		end
	end

	// AXI4-Lite write side: address and data are taken in either order.
	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold && !s_axi_bvalid;
	assign wr_fire       = aw_hold && w_hold && !s_axi_bvalid;
	assign wr_ctrl_start = wr_fire && aw_addr_q == `OSL_A_CTRL &&
		w_strb_q[0] && w_data_q[0];
	assign wr_ctrl_loop  = wr_fire && aw_addr_q == `OSL_A_CTRL &&
		w_strb_q[0] && w_data_q[1];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold      <= 1'b0;
			w_hold       <= 1'b0;
			aw_addr_q    <= 8'h00;
			w_data_q     <= 32'h0000_0000;
			w_strb_q     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `OSL_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold   <= 1'b1;
				aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold   <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold      <= 1'b0;
				w_hold       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_q <= `OSL_A_INT_MASK) ?
					`OSL_RESP_OKAY : `OSL_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			temp     <= 8'h00;
			def_idx  <= 5'h00;
			int_mask <= 3'h0;
		end else if (wr_fire && w_strb_q[0]) begin
			case (aw_addr_q)
				`OSL_A_TEMP:     temp     <= w_data_q[7:0];
				`OSL_A_DEF_IDX:  def_idx  <= w_data_q[4:0];
				`OSL_A_INT_MASK: int_mask <= w_data_q[2:0];
				default:         temp     <= temp;
			endcase
		end
	end

	// Hardware events win over a write-one clear in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_stat <= 3'h0;
		end else begin
			int_stat <= (int_stat & ~((wr_fire && w_strb_q[0] &&
				aw_addr_q == `OSL_A_INT_STAT) ? w_data_q[2:0] : 3'h0)) |
				{ev_loop, ev_stop, ev_done};
		end
	end

	assign irq = |(int_stat & int_mask);

	// Defaults read back as override bytes only when the key matched.
	assign def_byte = key_ok ? def_mem_q : osl_builtin(def_idx);

	always_comb begin
		rd_ok  = 1'b1;
		rd_mux = 32'h0000_0000;
		case ({s_axi_araddr[7:2], 2'b00})
			`OSL_A_CTRL:     rd_mux = 32'h0000_0000;
			`OSL_A_TEMP:     rd_mux = {24'h000000, temp};
			`OSL_A_CMD:      rd_mux = {31'h0, deep_sleep};
			`OSL_A_STATUS:   rd_mux = {24'h000000, loop_ok, loop_busy,
				deep_sleep, key_ok, bank_sel, load_valid,
				otp_req, 1'b0};
			`OSL_A_RANGE:    rd_mux = {11'h000, otp_addr, 3'h0, sel_range};
			`OSL_A_HDR0:     rd_mux = {hdr[3], hdr[2], hdr[1], hdr[0]};
			`OSL_A_HDR1:     rd_mux = {hdr[7], hdr[6], hdr[5], hdr[4]};
			`OSL_A_SHAPE:    rd_mux = three_colour_mode ?
				{24'h000000, `OSL_TRI_STAGES, 1'b0, `OSL_TRI_TABLES} :
				{24'h000000, `OSL_DUO_STAGES, 1'b0, `OSL_DUO_TABLES};
			`OSL_A_DEF_IDX:  rd_mux = {27'h0, def_idx};
			`OSL_A_DEF_DATA: rd_mux = {24'h000000, def_byte};
			`OSL_A_INT_STAT: rd_mux = {29'h0, int_stat};
			`OSL_A_INT_MASK: rd_mux = {29'h0, int_mask};
			default:         rd_ok  = 1'b0;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `OSL_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_ok ? `OSL_RESP_OKAY : `OSL_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	a_bank_fallback: assert property (@(posedge aclk) disable iff (!aresetn)
		state == osl_pkg::OSL_ST_CHK0 && otp_ack &&
		otp_rdata != `OSL_CHECK_CODE |=> state == osl_pkg::OSL_ST_CHK1 &&
		otp_addr == `OSL_BANK1) else $error("second bank not tried");
	a_bank_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		state == osl_pkg::OSL_ST_CHK1 && otp_ack &&
		otp_rdata != `OSL_CHECK_CODE |=> ev_stop ##1 int_stat[1])
		else $error("refresh not stopped without bank");
	a_range_first: assert property (@(posedge aclk) disable iff (!aresetn)
		state == osl_pkg::OSL_ST_BND && otp_ack && cmp_hit |=>
		state == osl_pkg::OSL_ST_HDR && sel_range == $past(idx))
		else $error("wrong range chosen");
	a_final_slot: assert property (@(posedge aclk) disable iff (!aresetn)
		state == osl_pkg::OSL_ST_BND && otp_ack && !cmp_hit &&
		idx == `OSL_BND_LAST |=> sel_range == `OSL_FINAL_SLOT)
		else $error("final slot not used");
	a_signed_cmp: assert property (@(posedge aclk) disable iff (!aresetn)
		state == osl_pkg::OSL_ST_BND && otp_ack && temp == 8'hF6 &&
		otp_rdata == 8'hF1 |=> state == osl_pkg::OSL_ST_BND)
		else $error("minus ten matched minus fifteen");
	a_term_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		state == osl_pkg::OSL_ST_BND && otp_ack &&
		otp_rdata == `OSL_TERM_CODE |=> state == osl_pkg::OSL_ST_HDR)
		else $error("terminator ignored");
	a_key_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		mem_we |-> key_ok)
		else $error("override loaded without key");
	a_no_key: assert property (@(posedge aclk) disable iff (!aresetn)
		state == osl_pkg::OSL_ST_KEY && otp_ack &&
		otp_rdata != `OSL_CHECK_CODE |=> !key_ok &&
		panel_byte == `OSL_PSR_DEFAULT) else $error("default lost");
	a_record_addr: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(state == osl_pkg::OSL_ST_HDR) |-> otp_addr == bank_base +
		`OSL_REC_OFS + 13'({8'h00, sel_range} * `OSL_REC_LEN))
		else $error("record address wrong");
	a_table_shape: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `OSL_A_SHAPE |=>
		s_axi_rdata[7:0] == (three_colour_mode ? 8'h84 : 8'h65))
		else $error("table shape wrong");
	a_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		deep_sleep |=> deep_sleep && (state == osl_pkg::OSL_ST_IDLE ||
		$past(state) != osl_pkg::OSL_ST_IDLE))
		else $error("left deep sleep without reset");
	a_loop_judge: assert property (@(posedge aclk) disable iff (!aresetn)
		loop_busy && loop_cnt == 16'h0000 |=> ev_loop && !loop_out_pin &&
		loop_ok == $past(loop_in_pin)) else $error("loop verdict wrong");
endmodule
`default_nettype wire

// ==== src/osl_params.svh ====
// Purpose: Constants of the setting loader: offsets, fields, codes, timing.
// Assumes: 13-bit byte addresses into the nonvolatile array.
// Notes:   Included by bare name; definitions only.
`ifndef OSL_PARAMS_SVH
`define OSL_PARAMS_SVH

`define OSL_CHECK_CODE   8'hA5
`define OSL_BANK0        13'h0000
`define OSL_BANK1        13'h1000
`define OSL_KEY_OFS      13'h0001
`define OSL_DEF_FIRST    5'h02
`define OSL_DEF_LAST     5'h13
`define OSL_BND_OFS      13'h001A
`define OSL_BND_LAST     5'h0F
`define OSL_FINAL_SLOT   5'h10
`define OSL_TERM_CODE    8'h7F
`define OSL_REC_OFS      13'h002A
`define OSL_REC_LEN      13'h00E9
`define OSL_HDR_LAST     5'h08
`define OSL_PSR_DEFAULT  8'h0F
`define OSL_SLEEP_CODE   8'h07

`define OSL_TRI_TABLES   3'h4
`define OSL_TRI_STAGES   4'h8
`define OSL_DUO_TABLES   3'h5
`define OSL_DUO_STAGES   4'h6

`define OSL_CLK_NS       5
`define OSL_LOOP_NS      1000
`define OSL_LOOP_CYC     (`OSL_LOOP_NS / `OSL_CLK_NS)

`define OSL_A_CTRL       8'h00
`define OSL_A_TEMP       8'h04
`define OSL_A_CMD        8'h08
`define OSL_A_STATUS     8'h0C
`define OSL_A_RANGE      8'h10
`define OSL_A_HDR0       8'h14
`define OSL_A_HDR1       8'h18
`define OSL_A_SHAPE      8'h1C
`define OSL_A_DEF_IDX    8'h20
`define OSL_A_DEF_DATA   8'h24
`define OSL_A_INT_STAT   8'h28
`define OSL_A_INT_MASK   8'h2C

`define OSL_INT_DONE     0
`define OSL_INT_STOP     1
`define OSL_INT_LOOP     2

`define OSL_RESP_OKAY    2'h0
`define OSL_RESP_SLVERR  2'h2

`endif

// ==== src/osl_pkg.sv ====
// Purpose: Types shared by the setting loader.
// Assumes: Nothing beyond the constants header.
// Notes:   Loader states carry explicit binary codes.
`default_nettype none
package osl_pkg;
	typedef enum logic [2:0] {
		OSL_ST_IDLE = 3'b000,
		OSL_ST_CHK0 = 3'b001,
		OSL_ST_CHK1 = 3'b010,
		OSL_ST_KEY  = 3'b011,
		OSL_ST_DEF  = 3'b100,
		OSL_ST_BND  = 3'b101,
		OSL_ST_HDR  = 3'b110
	} osl_state_t;
endpackage
`default_nettype wire
